// file: tb/periph_mem.sv
// Bus-side memory and peripheral model for the core
`timescale 1ns/10ps
`default_nettype none
module periph_mem (
    input  wire logic        clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic        mem_byte,
    output logic      [15:0] mem_rdata
);
    logic [15:0] m [logic [15:0]];
    logic [15:0] w;
    initial mem_rdata = 16'h0000;
    // Unwritten words decode as a register move, keeping the core busy
    always @(posedge clk) begin
        w = m.exists(mem_addr) ? m[mem_addr] : 16'h4404;
        if (mem_wr && !mem_byte) w = mem_wdata;
        if (mem_wr && mem_byte) w[7:0] = mem_wdata[7:0];
        if (mem_wr) m[mem_addr] = w;
        // Idle bus flips so stale data never looks valid
        mem_rdata <= mem_rd ? w : ~mem_rdata;
    end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the processing core
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk, reset, mem_rd, mem_wr, mem_byte, dbg_wr, dbg_rd;
    logic        irq_ack, mclk_on, fll_on, osc_dc_on, xtal_on, xtal_tick;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, dbg_wdata, dbg_rdata, v;
    logic [14:0] irq_req;
    logic [7:0]  module_enable;
    logic [4:0]  dbg_addr;
    logic [3:0]  irq_ack_idx;
    logic [2:0]  sleep_level;
    int          fails = 0, tests_run = 0, i, l;
    logic [15:0] srv [6] = '{16'h00c0, 16'h0010, 16'h0050, 16'h0090,
                             16'h00d0, 16'h00f0};
    cpu_core cpu_core_inst (.clk, .reset, .mem_addr, .mem_wdata, .mem_rd,
        .mem_wr, .mem_byte, .mem_rdata, .irq_req, .irq_ack, .irq_ack_idx,
        .dbg_addr, .dbg_wdata, .dbg_wr, .dbg_rd, .dbg_rdata, .module_enable,
        .sleep_level, .mclk_on, .fll_on, .osc_dc_on, .xtal_on, .xtal_tick);
    periph_mem periph_mem_inst (.clk, .mem_addr, .mem_wdata, .mem_rd,
        .mem_wr, .mem_byte, .mem_rdata);
    // Clock controls per level: mclk, loop, dc generator, crystal
    function automatic logic [3:0] clk_exp(input int lv);
        return (lv > 4) ? 4'hf : 4'(20'h013bf >> (4 * lv));
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        dbg_wr <= 1'b1;
        dbg_addr <= a;
        dbg_wdata <= d;
        @(posedge clk);
        dbg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        dbg_rd <= 1'b1;
        dbg_addr <= a;
        @(posedge clk);
        dbg_rd <= 1'b0;
        @(negedge clk);
        chk(dbg_rdata, e);
    endtask
    task automatic stop_test();
        if (fails == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #200000;
        fails++;
        stop_test();
    end
    initial begin
        {reset, irq_req, dbg_addr, dbg_wdata, dbg_wr, dbg_rd} = '1;
        {irq_req, dbg_addr, dbg_wdata, dbg_wr, dbg_rd} = '0;
        void'($urandom(50));
        periph_mem_inst.m[16'hfffe] = 16'hc000;
        periph_mem_inst.m[16'hfffc] = 16'h8000;
        periph_mem_inst.m[16'h8000] = 16'h4536;
        periph_mem_inst.m[16'h8002] = 16'h1300;
        periph_mem_inst.m[16'h0200] = 16'h1234;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk(mem_rd ? mem_addr : 16'h0, 16'hfffe);
        chk({sleep_level, mclk_on, fll_on, osc_dc_on, xtal_on}, 16'h7f);
        chk({8'h0, module_enable}, 16'h0);
        repeat (2) @(negedge clk);
        for (i = 0; i < 8; i++) begin
            chk(mem_rd ? mem_addr : 16'h0, 16'hc000 + 16'(2 * i));
            @(negedge clk);
        end
        for (l = 0; l < 200 && xtal_tick !== 1'b1; l++) @(negedge clk);
        for (l = 1; l < 200; l++) begin
            @(negedge clk);
            if (xtal_tick === 1'b1) break;
        end
        chk(16'(l), 16'h0040);
        rd(5'h02, 16'h0000);
        wr(5'h01, 16'h0400);
        for (i = 4; i < 16; i++) begin
            v = 16'($urandom);
            wr(5'(i), v);
            rd(5'(i), v);
        end
        v = 16'($urandom) & 16'h00ff;
        wr(5'h10, v);
        rd(5'h10, v);
        chk({8'h0, module_enable}, v);
        rd(5'h11, 16'h0000);
        for (i = 0; i < 6; i++) begin
            l = (i == 0) ? 7 : i - 1;
            wr(5'h02, srv[i]);
            @(negedge clk);
            chk({sleep_level, mclk_on, fll_on, osc_dc_on, xtal_on},
                {9'h0, 3'(l), clk_exp(l)});
        end
        wr(5'h02, 16'hffff);
        rd(5'h02, 16'h01ff);
        wr(5'h05, 16'h0200);
        wr(5'h02, 16'h0090);
        @(posedge clk);
        irq_req[14] <= 1'b1;
        for (i = 0; i < 50 && irq_ack !== 1'b1; i++) @(negedge clk);
        chk({11'h0, irq_ack, irq_ack_idx}, 16'h001e);
        @(posedge clk);
        irq_req[14] <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk({13'h0, sleep_level}, 16'h0007);
        repeat (30) @(negedge clk);
        chk({13'h0, sleep_level}, 16'h0002);
        rd(5'h02, 16'h0090);
        rd(5'h05, 16'h0202);
        rd(5'h06, 16'h1234);
        stop_test();
    end
endmodule
`default_nettype wire

// file: verilog/cpu_core.sv
// 16-bit processing core: decoder, sequencer, status word, sleep control
`timescale 1ns/10ps
`default_nettype none
`include "cpu_core_defines.svh"
module cpu_core
    import cpu_core_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    output logic [15:0]              mem_addr,
    output logic [15:0]              mem_wdata,
    output logic                     mem_rd,
    output logic                     mem_wr,
    output logic                     mem_byte,
    input  wire logic [15:0]         mem_rdata,
    input  wire logic [`NUM_IRQ-1:0] irq_req,
    output logic                     irq_ack,
    output logic [3:0]               irq_ack_idx,
    input  wire logic [4:0]          dbg_addr,
    input  wire logic [15:0]         dbg_wdata,
    input  wire logic                dbg_wr,
    input  wire logic                dbg_rd,
    output logic [15:0]              dbg_rdata,
    output logic [7:0]               module_enable,
    output logic [2:0]               sleep_level,
    output logic                     mclk_on,
    output logic                     fll_on,
    output logic                     osc_dc_on,
    output logic                     xtal_on,
    output logic                     xtal_tick
);
    core_st_t r;
    core_st_t n;
    logic [15:0]          ins, msk, inc, pc, sp, sr, src_v, dst_v, ea;
    logic [15:0]          a, b, bx, res, base;
    logic [16:0]          sum;
    logic [`NUM_IRQ-2:0]  irq_m;
    logic [3:0]           sreg, dreg, pidx;
    logic                 fmt1, fmt2, fjmp, bw, pend, jtake, cin;
    logic                 src_ok, do_exec, is_mem, setf, wr, fc, fv;
    logic                 m_rd, m_wr, m_byte;
    logic [15:0]          m_addr, m_wd;
    alu_op_t              op1;
    one_op_t              op2;

    // ****************************************
    // Sleep control from the status word
    // ****************************************
    // Clock controls only bite while the processor is halted
    assign sr = r.rf[`R_SR];
    always_comb begin
        if (!sr[`SR_HALT])
            sleep_level = `LVL_ACT;
        else if (sr[`SR_XSTOP])
            sleep_level = `LVL4;
        else if (sr[`SR_CG1] && sr[`SR_CG0])
            sleep_level = `LVL3;
        else if (sr[`SR_CG1])
            sleep_level = `LVL2;
        else if (sr[`SR_CG0])
            sleep_level = `LVL1;
        else
            sleep_level = `LVL0;
    end
    assign mclk_on   = !(sr[`SR_HALT] &&
                         (sr[`SR_CG1] || sr[`SR_XSTOP]));
    assign fll_on    = !(sr[`SR_HALT] && (sr[`SR_CG0] ||
                         sr[`SR_CG1] || sr[`SR_XSTOP]));
    assign osc_dc_on = !(sr[`SR_HALT] && ((sr[`SR_CG0] &&
                         sr[`SR_CG1]) || sr[`SR_XSTOP]));
    assign xtal_on   = !(sr[`SR_HALT] && sr[`SR_XSTOP]);
    assign xtal_tick     = r.xtick;
    assign module_enable = r.moden;
    assign irq_ack       = r.ack;
    assign irq_ack_idx   = r.irq_idx;
    assign dbg_rdata     = r.rdata;
    // Peripheral access is never gated by module enables
    assign mem_addr  = m_addr;
    assign mem_wdata = m_wd;
    assign mem_rd    = m_rd;
    assign mem_wr    = m_wr;
    assign mem_byte  = m_byte;

    // ****************************************
    // Sequencer and datapath
    // ****************************************
    always_comb begin
        n      = r;
        n.ack  = 1'b0;
        m_rd   = 1'b0;
        m_wr   = 1'b0;
        m_byte = 1'b0;
        m_addr = r.rf[`R_PC];
        m_wd   = 16'h0000;
        ins    = (r.st == S_DEC) ? mem_rdata : r.ir;
        fmt1   = ins[15:14] != 2'b00;
        fmt2   = ins[15:10] == 6'b000100;
        fjmp   = ins[15:13] == 3'b001;
        op1    = alu_op_t'(ins[15:12]);
        op2    = fmt2 ? one_op_t'(ins[9:7]) : F2_NONE;
        bw     = ins[6] && op2 != F2_SWPB && op2 != F2_SXT;
        sreg   = fmt1 ? ins[11:8] : ins[3:0];
        dreg   = ins[3:0];
        msk    = bw ? 16'h00ff : 16'hffff;
        inc    = (bw && sreg > `R_SP) ? 16'h0001 : 16'h0002;
        pc     = r.rf[`R_PC];
        sp     = r.rf[`R_SP];
        irq_m  = irq_req[`NUM_IRQ-2:0] & {(`NUM_IRQ-1){sr[`SR_GIE]}};
        pend   = irq_req[`NMI_BIT] || (|irq_m);
        pidx   = 4'h0;
        for (int i = 0; i < `NUM_IRQ - 1; i++) begin
            if (irq_m[i])
                pidx = 4'(i);
        end
        if (irq_req[`NMI_BIT])
            pidx = 4'(`NMI_BIT);
        case (ins[12:10])
            3'h0:    jtake = !sr[`SR_Z];
            3'h1:    jtake = sr[`SR_Z];
            3'h2:    jtake = !sr[`SR_C];
            3'h3:    jtake = sr[`SR_C];
            3'h4:    jtake = sr[`SR_N];
            3'h5:    jtake = sr[`SR_N] == sr[`SR_V];
            3'h6:    jtake = sr[`SR_N] != sr[`SR_V];
            default: jtake = 1'b1;
        endcase
        src_ok  = 1'b0;
        src_v   = 16'h0000;
        dst_v   = 16'h0000;
        do_exec = 1'b0;
        is_mem  = 1'b0;
        ea      = r.addr;
        base    = 16'h0000;
        case (r.st)
            S_RST: begin
                m_rd   = 1'b1;
                m_addr = `RESET_VEC;
                n.st   = S_VEC;
            end
            S_VEC: begin
                n.rf[`R_PC] = mem_rdata;
                n.st        = S_FETCH;
            end
            S_FETCH: begin
                if (pend) begin
                    n.st      = S_IRQ1;
                    n.ack     = 1'b1;
                    n.irq_idx = pidx;
                end else if (!sr[`SR_HALT]) begin
                    m_rd        = 1'b1;
                    n.rf[`R_PC] = pc + 16'h0002;
                    n.st        = S_DEC;
                end
            end
            S_DEC: begin
                n.ir   = ins;
                n.dmem = 1'b0;
                if (fjmp) begin
                    if (jtake)
                        n.rf[`R_PC] = pc + {{5{ins[9]}}, ins[9:0], 1'b0};
                    n.st = S_FETCH;
                end else if (!fmt1 && !fmt2) begin
                    n.st = S_FETCH;
                end else if (sreg == `R_CG) begin
                    src_ok = 1'b1;
                    case (ins[5:4])
                        2'b00:   src_v = 16'h0000;
                        2'b01:   src_v = 16'h0001;
                        2'b10:   src_v = 16'h0002;
                        default: src_v = 16'hffff;
                    endcase
                end else if (sreg == `R_SR && ins[5]) begin
                    src_ok = 1'b1;
                    src_v  = ins[4] ? 16'h0008 : 16'h0004;
                end else if (ins[5:4] == 2'b00) begin
                    src_ok = 1'b1;
                    src_v  = r.rf[sreg];
                end else if (ins[5:4] == 2'b01) begin
                    m_rd        = 1'b1;
                    n.addr      = pc;
                    n.rf[`R_PC] = pc + 16'h0002;
                    n.st        = S_SEXT;
                end else begin
                    m_rd   = 1'b1;
                    m_addr = r.rf[sreg];
                    n.addr = r.rf[sreg];
                    n.dmem = fmt2 && sreg != `R_PC;
                    if (ins[4])
                        n.rf[sreg] = r.rf[sreg] + inc;
                    n.st   = S_SRD;
                end
            end
            S_SEXT: begin
                if (sreg == `R_SR)
                    base = 16'h0000;
                else if (sreg == `R_PC)
                    base = r.addr;
                else
                    base = r.rf[sreg];
                m_rd   = 1'b1;
                m_addr = mem_rdata + base;
                n.addr = mem_rdata + base;
                n.dmem = fmt2;
                n.st   = S_SRD;
            end
            S_SRD: begin
                src_ok = 1'b1;
                src_v  = mem_rdata;
            end
            S_DEXT: begin
                if (dreg == `R_SR)
                    base = 16'h0000;
                else if (dreg == `R_PC)
                    base = r.addr;
                else
                    base = r.rf[dreg];
                ea     = mem_rdata + base;
                n.addr = ea;
                is_mem = 1'b1;
                src_v  = r.src;
                if (op1 == OP_MOV) begin
                    do_exec = 1'b1;
                end else begin
                    m_rd   = 1'b1;
                    m_addr = ea;
                    n.st   = S_DRD;
                end
            end
            S_DRD: begin
                do_exec = 1'b1;
                is_mem  = 1'b1;
                src_v   = r.src;
                dst_v   = mem_rdata;
            end
            S_POP1: begin
                n.rf[`R_SR] = mem_rdata & `SR_MASK;
                m_rd        = 1'b1;
                m_addr      = sp;
                n.rf[`R_SP] = sp + 16'h0002;
                n.st        = S_POP2;
            end
            S_POP2: begin
                n.rf[`R_PC] = mem_rdata;
                n.st        = S_FETCH;
            end
            S_IRQ1: begin
                m_wr        = 1'b1;
                m_addr      = sp - 16'h0002;
                m_wd        = pc;
                n.rf[`R_SP] = sp - 16'h0002;
                n.st        = S_IRQ2;
            end
            S_IRQ2: begin
                m_wr        = 1'b1;
                m_addr      = sp - 16'h0002;
                m_wd        = sr;
                n.rf[`R_SP] = sp - 16'h0002;
                n.rf[`R_SR] = sr & ~`SR_CLR;
                n.st        = S_IRQ3;
            end
            S_IRQ3: begin
                m_rd   = 1'b1;
                m_addr = `VEC_BASE | {11'h000, r.irq_idx, 1'b0};
                n.st   = S_VEC;
            end
            default: n.st = S_RST;
        endcase
        if (src_ok) begin
            n.src = src_v;
            if (fmt1 && ins[7]) begin
                m_rd        = 1'b1;
                m_addr      = pc;
                n.addr      = pc;
                n.rf[`R_PC] = pc + 16'h0002;
                n.st        = S_DEXT;
            end else begin
                do_exec = 1'b1;
                is_mem  = (r.st == S_SRD) && r.dmem;
                dst_v   = fmt1 ? r.rf[dreg] : src_v;
            end
        end
        a    = dst_v & msk;
        b    = src_v & msk;
        bx   = ((op1 == OP_SUBC || op1 == OP_SUB || op1 == OP_CMP) ?
                ~src_v : src_v) & msk;
        cin  = (op1 == OP_SUB || op1 == OP_CMP) ? 1'b1 :
               (op1 == OP_ADD) ? 1'b0 : sr[`SR_C];
        sum  = {1'b0, a} + {1'b0, bx} + {16'h0000, cin};
        res  = 16'h0000;
        setf = 1'b0;
        wr   = 1'b0;
        fc   = 1'b0;
        fv   = 1'b0;
        if (fmt2) begin
            setf = 1'b1;
            wr   = 1'b1;
            fc   = b[0];
            case (op2)
                F2_RRC:  res = bw ? {8'h00, sr[`SR_C], b[7:1]} :
                                    {sr[`SR_C], b[15:1]};
                F2_RRA:  res = bw ? {8'h00, b[7], b[7:1]} :
                                    {b[15], b[15:1]};
                F2_SWPB: begin
                    res  = {src_v[7:0], src_v[15:8]};
                    setf = 1'b0;
                end
                F2_SXT: begin
                    res = {{8{src_v[7]}}, src_v[7:0]};
                    fc  = res != 16'h0000;
                end
                default: begin
                    setf = 1'b0;
                    wr   = 1'b0;
                end
            endcase
        end else begin
            case (op1)
                OP_MOV: begin
                    res = b;
                    wr  = 1'b1;
                end
                OP_BIT, OP_AND: begin
                    res  = a & b;
                    setf = 1'b1;
                    wr   = op1 == OP_AND;
                    fc   = res != 16'h0000;
                end
                OP_BIC: begin
                    res = a & ~b & msk;
                    wr  = 1'b1;
                end
                OP_BIS: begin
                    res = a | b;
                    wr  = 1'b1;
                end
                OP_XOR: begin
                    res  = a ^ b;
                    setf = 1'b1;
                    wr   = 1'b1;
                    fc   = res != 16'h0000;
                    fv   = bw ? (a[7] && b[7]) : (a[15] && b[15]);
                end
                default: begin
                    res  = sum[15:0] & msk;
                    setf = 1'b1;
                    wr   = op1 != OP_CMP;
                    fc   = bw ? sum[8] : sum[16];
                    fv   = bw ? (a[7] == bx[7] && res[7] != a[7]) :
                                (a[15] == bx[15] && res[15] != a[15]);
                end
            endcase
        end
        if (do_exec) begin
            n.st = S_FETCH;
            if (op2 == F2_PUSH || op2 == F2_CALL) begin
                m_wr        = 1'b1;
                m_addr      = sp - 16'h0002;
                m_wd        = (op2 == F2_CALL) ? pc : b;
                m_byte      = op2 == F2_PUSH && bw;
                n.rf[`R_SP] = sp - 16'h0002;
                if (op2 == F2_CALL)
                    n.rf[`R_PC] = src_v;
            end else if (op2 == F2_IRET) begin
                m_rd        = 1'b1;
                m_addr      = sp;
                n.rf[`R_SP] = sp + 16'h0002;
                n.st        = S_POP1;
            end else begin
                if (setf) begin
                    n.rf[`R_SR][`SR_N] = bw ? res[7] : res[15];
                    n.rf[`R_SR][`SR_Z] = (res & msk) == 16'h0000;
                    n.rf[`R_SR][`SR_C] = fc;
                    n.rf[`R_SR][`SR_V] = fv;
                end
                if (wr && is_mem) begin
                    m_wr   = 1'b1;
                    m_addr = ea;
                    m_wd   = res;
                    m_byte = bw;
                end else if (wr && dreg != `R_CG) begin
                    n.rf[dreg] = (dreg == `R_SR) ? (res & `SR_MASK)
                                                 : (res & msk);
                end
                // Back-to-back fetch only when nothing redirects or halts
                if (!is_mem && dreg > `R_CG && !pend &&
                    !sr[`SR_HALT]) begin
                    m_rd        = 1'b1;
                    m_addr      = pc;
                    n.rf[`R_PC] = pc + 16'h0002;
                    n.st        = S_DEC;
                end
            end
        end
        // Debug writes win over the sequencer in the same cycle
        if (dbg_wr) begin
            if (!dbg_addr[4] && dbg_addr[3:0] != `R_CG)
                n.rf[dbg_addr[3:0]] = (dbg_addr[3:0] == `R_SR) ?
                                      (dbg_wdata & `SR_MASK) : dbg_wdata;
            else if (dbg_addr == `DBG_MODEN)
                n.moden = dbg_wdata[7:0];
        end
        if (!dbg_rd)
            n.rdata = 16'h0000;
        else if (!dbg_addr[4])
            n.rdata = r.rf[dbg_addr[3:0]];
        else if (dbg_addr == `DBG_MODEN)
            n.rdata = {8'h00, r.moden};
        else
            n.rdata = 16'h0000;
        n.xtick = 1'b0;
        if (xtal_on) begin
            if (r.xdiv == `XTAL_DIV - 8'd1) begin
                n.xdiv  = 8'h00;
                n.xtick = 1'b1;
            end else begin
                n.xdiv = r.xdiv + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r       <= '0;
            r.st    <= S_RST;
            r.moden <= `MODEN_RST;
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_vec_load;
        (mem_rd && mem_addr == `RESET_VEC) ##1
        (r.st == S_VEC) ##1 (r.rf[`R_PC] == $past(mem_rdata));
    endsequence
    property p_reset_vec;
        $fell(reset) |-> s_vec_load;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset vector not loaded");

    property p_halt_stall;
        (r.st == S_FETCH && sr[`SR_HALT] && !pend) |-> !mem_rd && !mem_wr;
    endproperty
    a_halt_stall: assert property (p_halt_stall)
        else $error("halted core touched the bus");

    property p_lvl1;
        sleep_level == `LVL1 |-> mclk_on && !fll_on && xtal_on;
    endproperty
    a_lvl1: assert property (p_lvl1)
        else $error("level one clock state wrong");

    property p_lvl2;
        sleep_level == `LVL2 |-> !mclk_on && osc_dc_on && xtal_on;
    endproperty
    a_lvl2: assert property (p_lvl2)
        else $error("level two clock state wrong");

    property p_lvl3;
        sleep_level == `LVL3 |-> !osc_dc_on && !fll_on && xtal_on;
    endproperty
    a_lvl3: assert property (p_lvl3)
        else $error("level three clock state wrong");

    property p_lvl4;
        sleep_level == `LVL4 |-> !xtal_on && !mclk_on && !osc_dc_on;
    endproperty
    a_lvl4: assert property (p_lvl4)
        else $error("level four clock state wrong");

    sequence s_irq_entry;
        (mem_wr && mem_wdata == pc) ##1 mem_wr ##1
        (mem_rd && mem_addr >= `VEC_BASE) ##2
        (!sr[`SR_GIE] && !sr[`SR_HALT] && pc == $past(mem_rdata));
    endsequence
    property p_irq_entry;
        irq_ack |-> s_irq_entry;
    endproperty
    a_irq_entry: assert property (p_irq_entry)
        else $error("interrupt entry sequence wrong");

    property p_reg_reg;
        (r.st == S_DEC && fmt1 && !ins[7] && ins[5:4] == 2'b00 &&
         sreg > `R_CG && dreg > `R_CG && !pend && !dbg_wr &&
         !sr[`SR_HALT])
        |-> mem_rd ##1 (r.st == S_DEC);
    endproperty
    a_reg_reg: assert property (p_reg_reg)
        else $error("register operation took more than one cycle");

    property p_postinc;
        (r.st == S_DEC && (fmt1 || fmt2) && ins[5:4] == 2'b11 &&
         sreg > `R_CG && !dbg_wr) |=>
        r.rf[$past(sreg)] == $past(r.rf[sreg]) + $past(inc);
    endproperty
    a_postinc: assert property (p_postinc)
        else $error("post-increment step wrong");
endmodule
`default_nettype wire

// file: verilog/cpu_core_defines.svh
// Core constants: status word layout, vectors, debug map, timing
`ifndef CPU_CORE_DEFINES_SVH
`define CPU_CORE_DEFINES_SVH
// Functional notes
// - Sixteen registers, four special, twelve general
// - Register-to-register operation takes one clock; the core takes two when the destination is PC, SP, SR or CG
// - Decode two-operand, one-operand and jump formats
// - Seven source modes, four destination modes
// - Word by default, byte when byte bit set
// - Jump takes a PC offset, call takes any mode; call pushes PC
// - Interrupt wakes core; return restores old mode
// - Crystal tick derived from master clock multiple
// - Active state executes with any modules enabled
// - Level zero: halt, clocks and loop run
// - Level one: halt, clocks run, loop frozen
// - Level two: master clock and loop stopped
// - Level three: oscillator DC generator also off
// - Level four: crystal oscillator also stopped
// - Four status bits steer halt and clocks
// - Status word bit layout, bits 15-9 reserved
// - Module-enable bits stop or enable peripherals
// - Peripheral registers reachable whatever enable state
// - Vectors occupy 0ffe0h through 0ffffh
// - Vector word loads program counter
// - Peripherals reached as memory over bus
// - Reset vector at 0fffeh, highest priority
`define R_PC       4'd0
`define R_SP       4'd1
`define R_SR       4'd2
`define R_CG       4'd3
`define SR_C       0
`define SR_Z       1
`define SR_N       2
`define SR_GIE     3
`define SR_HALT    4
`define SR_XSTOP   5
`define SR_CG0     6
`define SR_CG1     7
`define SR_V       8
`define SR_MASK    16'h01ff
`define SR_CLR     16'h00f8
`define RESET_VEC  16'hfffe
`define VEC_BASE   16'hffe0
`define NUM_IRQ    15
`define NMI_BIT    14
`define DBG_MODEN  5'h10
`define MODEN_RST  8'h00
`define XTAL_DIV   8'd64
`define LVL0       3'd0
`define LVL1       3'd1
`define LVL2       3'd2
`define LVL3       3'd3
`define LVL4       3'd4
`define LVL_ACT    3'd7
`endif

// file: verilog/cpu_core_pkg.sv
// Types of the processing core: states, opcodes, state record
package cpu_core_pkg;
    typedef enum logic [3:0] {
        S_RST = 4'h0, S_VEC = 4'h1, S_FETCH = 4'h2, S_DEC = 4'h3,
        S_SEXT = 4'h4, S_SRD = 4'h5, S_DEXT = 4'h6, S_DRD = 4'h7,
        S_POP1 = 4'h8, S_POP2 = 4'h9, S_IRQ1 = 4'ha, S_IRQ2 = 4'hb,
        S_IRQ3 = 4'hc
    } state_t;
    typedef enum logic [3:0] {
        OP_MOV = 4'h4, OP_ADD = 4'h5, OP_ADDC = 4'h6, OP_SUBC = 4'h7,
        OP_SUB = 4'h8, OP_CMP = 4'h9, OP_DADD = 4'ha, OP_BIT = 4'hb,
        OP_BIC = 4'hc, OP_BIS = 4'hd, OP_XOR = 4'he, OP_AND = 4'hf
    } alu_op_t;
    typedef enum logic [2:0] {
        F2_RRC = 3'h0, F2_SWPB = 3'h1, F2_RRA = 3'h2, F2_SXT = 3'h3,
        F2_PUSH = 3'h4, F2_CALL = 3'h5, F2_IRET = 3'h6, F2_NONE = 3'h7
    } one_op_t;
    typedef struct packed {
        state_t           st;
        logic [15:0][15:0] rf;
        logic [15:0]      ir;
        logic [15:0]      src;
        logic [15:0]      addr;
        logic             dmem;
        logic [7:0]       moden;
        logic [15:0]      rdata;
        logic [7:0]       xdiv;
        logic             xtick;
        logic [3:0]       irq_idx;
        logic             ack;
    } core_st_t;
endpackage
